// file: design/prsc_pkg.sv
// package for the power, reset and security controller
// assumes a 40 MHz system clock and a plain strobe register port
package prsc_pkg;

  // register offsets (word index on the plain port)
  localparam logic [3:0] prsc_addr_control  = 4'h0;
  localparam logic [3:0] prsc_addr_status   = 4'h1;
  localparam logic [3:0] prsc_addr_security = 4'h2;

  // control register fields
  localparam int prsc_ctl_stop_dis_tmp  = 0;
  localparam int prsc_ctl_wait_dis_tmp  = 1;
  localparam int prsc_ctl_stop_dis_perm = 2;
  localparam int prsc_ctl_wait_dis_perm = 3;
  localparam int prsc_ctl_sw_reset      = 4;

  // timing
  localparam int prsc_clk_mhz       = 40;
  localparam int prsc_system_clock_max_mhz = 60;
  localparam int prsc_por_ext_log2  = 21;
  localparam int prsc_por_ext_cycles = 2 ** prsc_por_ext_log2;
  localparam int prsc_window_cycles = 32;
  localparam logic [20:0] prsc_cnt_zero = 21'h000000;

  // boot vector used when secured
  localparam logic [23:0] prsc_secure_boot_addr = 24'h020000;
  // arbitrary: security byte pattern that means unsecured
  localparam logic [15:0] prsc_unsecure_key = 16'h5aa5;

  typedef enum logic [2:0] {
    prsc_st_por_ext = 3'b000,
    prsc_st_clk_win = 3'b001,
    prsc_st_per_win = 3'b010,
    prsc_st_core_win = 3'b011,
    prsc_st_run     = 3'b100
  } prsc_rst_state_type;

  typedef enum logic [1:0] {
    prsc_mode_run  = 2'b00,
    prsc_mode_wait = 2'b01,
    prsc_mode_stop = 2'b10
  } prsc_pwr_mode_type;

  typedef enum logic [1:0] {
    prsc_boot_internal = 2'b00,
    prsc_boot_external = 2'b01,
    prsc_boot_secure   = 2'b10
  } prsc_boot_mode_type;

  typedef struct packed {
    logic core_clk_en;
    logic mem_clk_en;
    logic periph_clk_en;
  } prsc_clk_en_type;

  typedef struct packed {
    logic periph_rst_n;
    logic core_rst_n;
    logic app_run;
  } prsc_rst_out_type;

endpackage

// file: design/prsc_top.sv
// power mode, reset sequencing and flash security interlock
// assumes synchronous inputs and a core that raises one-cycle
// stop and wait instruction pulses
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - run mode keeps core, memory and peripheral clocks enabled
// - wait stops core and memory clocks; unmasked interrupt resumes
// - stop leaves only on can traffic, async irq, software or watchdog reset, pin, power-on
// - peripherals share one bus clock equal to core clock, max 60 MHz
// - stop entry leaves the pll exactly as software set it
// - control writes disable stop/wait; permanent disable lasts until reset
// - four reset sources: pin and power-on async, software and watchdog sync
// - power-on reset is stretched for 2^21 clocks
// - then three 32-clock windows: clocking, peripherals, core
// - pin and power-on reset assert asynchronously and release on a rising clock edge
// - two non-volatile security bytes decide security across resets
// - secured: no external program space, no external boot, no debug reads
// - boot selects internal, external or secure mode
// - secured boot fetches from 0x02_0000 with external space off
// - secured: external boot pin during reset is ignored
// - test access port stays active at boot regardless of security
// - security bytes drive the core debug-read-disable at reset
module prsc_top
  import prsc_pkg::*;
(
  // clock and reset sources
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        por_n,
  input  wire logic        watchdog_reset_source,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // core power events
  input  wire logic        stop_instr,
  input  wire logic        wait_instr,
  input  wire logic        periph_irq,
  input  wire logic        async_irq,
  input  wire logic        can_activity,
  // flash and boot
  input  wire logic [15:0] flash_security_bytes,
  input  wire logic        external_boot_pin,
  // clock enables and staged resets
  output prsc_clk_en_type  clk_en,
  output prsc_rst_out_type rst_out,
  output prsc_pwr_mode_type pwr_mode,
  // security outputs
  output prsc_boot_mode_type boot_mode,
  output logic      [23:0] boot_addr,
  output logic             ext_pspace_en,
  output logic             debug_read_disable,
  output logic             tap_enable
);

  ////////////////////////////////////////////////////////////////////////
  // reset merge and release synchroniser
  logic rst_sync1;
  logic rst_sync2;
  logic por_sync1;
  logic por_sync2;
  logic por_sync3;
  logic sw_reset_pulse;
  logic sync_reset;
  logic int_rst_n;

  // pin and power-on assert at once, release on a clock edge
  always_ff @(posedge core_clk or negedge resetn or negedge por_n) begin
    if (!resetn || !por_n) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end

  // power-on alone marks that the long stretch is needed
  // one stage longer than the release path, so the sequencer sees it low
  // on its first clock only after a power-on
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      por_sync1 <= 1'b0;
      por_sync2 <= 1'b0;
      por_sync3 <= 1'b0;
    end else begin
      por_sync1 <= 1'b1;
      por_sync2 <= por_sync1;
      por_sync3 <= por_sync2;
    end
  end

  assign sync_reset = sw_reset_pulse || watchdog_reset_source;
  assign int_rst_n  = rst_sync2;

  ////////////////////////////////////////////////////////////////////////
  // reset release sequencer
  prsc_rst_state_type rst_state;
  prsc_rst_state_type next_rst_state;
  logic [20:0]        rst_cnt;
  logic [20:0]        next_rst_cnt;
  logic               por_seen;
  logic               next_por_seen;
  prsc_rst_out_type   next_rst_out;

  function automatic logic cnt_done(input logic [20:0] c,
                                    input int unsigned lim);
    cnt_done = (c == 21'(lim - 1));
  endfunction

  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt + 21'h000001;
    next_por_seen  = por_seen;
    if (sync_reset) begin
      next_rst_state = prsc_st_clk_win;
      next_rst_cnt   = prsc_cnt_zero;
    end else begin
      unique case (rst_state)
        prsc_st_por_ext: begin
          if (!por_seen && !por_sync3) begin
            next_por_seen = 1'b1;
          end else if (!por_seen ||
                       cnt_done(rst_cnt, prsc_por_ext_cycles)) begin
            next_rst_state = prsc_st_clk_win;
            next_rst_cnt   = prsc_cnt_zero;
            next_por_seen  = 1'b0;
          end
        end
        prsc_st_clk_win: begin
          if (cnt_done(rst_cnt, prsc_window_cycles)) begin
            next_rst_state = prsc_st_per_win;
            next_rst_cnt   = prsc_cnt_zero;
          end
        end
        prsc_st_per_win: begin
          if (cnt_done(rst_cnt, prsc_window_cycles)) begin
            next_rst_state = prsc_st_core_win;
            next_rst_cnt   = prsc_cnt_zero;
          end
        end
        prsc_st_core_win: begin
          if (cnt_done(rst_cnt, prsc_window_cycles)) begin
            next_rst_state = prsc_st_run;
            next_rst_cnt   = prsc_cnt_zero;
          end
        end
        prsc_st_run: next_rst_cnt = prsc_cnt_zero;
        default: begin
          next_rst_state = prsc_st_por_ext;
          next_rst_cnt   = prsc_cnt_zero;
        end
      endcase
    end
    next_rst_out.periph_rst_n = (next_rst_state == prsc_st_core_win) ||
                                (next_rst_state == prsc_st_run);
    next_rst_out.core_rst_n   = (next_rst_state == prsc_st_run);
    next_rst_out.app_run      = (next_rst_state == prsc_st_run);
  end

  // por_seen is taken from the synchroniser at first clock, not at reset
  always_ff @(posedge core_clk or negedge int_rst_n) begin
    if (!int_rst_n) begin
      rst_state <= prsc_st_por_ext;
      rst_cnt   <= prsc_cnt_zero;
      por_seen  <= 1'b0;
      rst_out   <= '0;
    end else begin
      rst_state <= next_rst_state;
      rst_cnt   <= next_rst_cnt;
      por_seen  <= next_por_seen;
      rst_out   <= next_rst_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and instruction disables
  logic [4:0]  ctl;
  logic [4:0]  next_ctl;
  logic        stop_dis;
  logic        wait_dis;

  always_comb begin
    next_ctl = ctl;
    next_ctl[prsc_ctl_sw_reset] = 1'b0;
    if (reg_wr && reg_addr == prsc_addr_control) begin
      next_ctl[prsc_ctl_stop_dis_tmp] = reg_wdata[prsc_ctl_stop_dis_tmp];
      next_ctl[prsc_ctl_wait_dis_tmp] = reg_wdata[prsc_ctl_wait_dis_tmp];
      // permanent bits only set; only a reset clears them
      next_ctl[prsc_ctl_stop_dis_perm] = ctl[prsc_ctl_stop_dis_perm] ||
                                 reg_wdata[prsc_ctl_stop_dis_perm];
      next_ctl[prsc_ctl_wait_dis_perm] = ctl[prsc_ctl_wait_dis_perm] ||
                                 reg_wdata[prsc_ctl_wait_dis_perm];
      next_ctl[prsc_ctl_sw_reset] = reg_wdata[prsc_ctl_sw_reset];
    end
    // software and watchdog resets also end a permanent disable
    if (sync_reset) next_ctl = '0;
  end

  always_ff @(posedge core_clk or negedge int_rst_n) begin
    if (!int_rst_n) ctl <= '0;
    else ctl <= next_ctl;
  end

  assign sw_reset_pulse = ctl[prsc_ctl_sw_reset];
  assign stop_dis = ctl[prsc_ctl_stop_dis_tmp] || ctl[prsc_ctl_stop_dis_perm];
  assign wait_dis = ctl[prsc_ctl_wait_dis_tmp] || ctl[prsc_ctl_wait_dis_perm];

  ////////////////////////////////////////////////////////////////////////
  // power mode; the pll is outside and never touched here
  prsc_pwr_mode_type next_pwr_mode;
  prsc_clk_en_type   next_clk_en;

  always_comb begin
    next_pwr_mode = pwr_mode;
    unique case (pwr_mode)
      prsc_mode_run: begin
        if (stop_instr && !stop_dis) next_pwr_mode = prsc_mode_stop;
        else if (wait_instr && !wait_dis) next_pwr_mode = prsc_mode_wait;
      end
      prsc_mode_wait: begin
        if (periph_irq || async_irq) next_pwr_mode = prsc_mode_run;
      end
      prsc_mode_stop: begin
        // clocked interrupts cannot wake stop; can wake drops the frame
        if (async_irq || can_activity) next_pwr_mode = prsc_mode_run;
      end
      default: next_pwr_mode = prsc_mode_run;
    endcase
    // one shared bus clock enable for all peripherals
    next_clk_en.core_clk_en   = (next_pwr_mode == prsc_mode_run);
    next_clk_en.mem_clk_en    = (next_pwr_mode == prsc_mode_run);
    next_clk_en.periph_clk_en = (next_pwr_mode != prsc_mode_stop);
  end

  // watchdog, pin and power-on leave stop through the reset path
  always_ff @(posedge core_clk or negedge int_rst_n) begin
    if (!int_rst_n) begin
      pwr_mode <= prsc_mode_run;
      clk_en   <= '1;
    end else if (sync_reset) begin
      pwr_mode <= prsc_mode_run;
      clk_en   <= '1;
    end else begin
      pwr_mode <= next_pwr_mode;
      clk_en   <= next_clk_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // security and boot mode, latched in the peripheral window while peripherals are still held in reset
  logic               secured;
  prsc_boot_mode_type next_boot_mode;
  logic               latch_sec;

  assign secured   = (flash_security_bytes != prsc_unsecure_key);
  assign latch_sec = (rst_state == prsc_st_per_win);

  always_comb begin
    if (secured) next_boot_mode = prsc_boot_secure;
    else if (external_boot_pin) next_boot_mode = prsc_boot_external;
    else next_boot_mode = prsc_boot_internal;
  end

  always_ff @(posedge core_clk or negedge int_rst_n) begin
    if (!int_rst_n) begin
      // safe until the bytes have been read
      boot_mode          <= prsc_boot_secure;
      boot_addr          <= prsc_secure_boot_addr;
      ext_pspace_en      <= 1'b0;
      debug_read_disable <= 1'b1;
      tap_enable         <= 1'b1;
    end else if (latch_sec) begin
      boot_mode          <= next_boot_mode;
      boot_addr          <= prsc_secure_boot_addr;
      ext_pspace_en      <= !secured;
      debug_read_disable <= secured;
      tap_enable         <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        prsc_addr_control:  next_rdata = {11'h000, ctl};
        prsc_addr_status:   next_rdata = {9'h000, boot_mode, pwr_mode,
                                          rst_state};
        prsc_addr_security: next_rdata = {15'h0000, secured};
        default:            next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge int_rst_n) begin
    if (!int_rst_n) reg_rdata <= 16'h0000;
    else reg_rdata <= next_rdata;
  end

endmodule

`default_nettype wire

// file: verification/prsc_top_assertions.sv
// assertions for the power, reset and security controller
// bound onto prsc_top from the testbench top; por_n stays high
`timescale 1ns/1ps
`default_nettype none
module prsc_top_chk
  import prsc_pkg::*;
(
  // clock, reset and events
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               watchdog_reset_source,
  input wire logic               stop_instr,
  input wire logic               wait_instr,
  input wire logic               periph_irq,
  input wire logic               async_irq,
  input wire logic               can_activity,
  input wire logic [15:0]        flash_security_bytes,
  input wire logic               external_boot_pin,
  // outputs watched
  input wire prsc_clk_en_type    clk_en,
  input wire prsc_rst_out_type   rst_out,
  input wire prsc_pwr_mode_type  pwr_mode,
  input wire prsc_boot_mode_type boot_mode,
  input wire logic [23:0]        boot_addr,
  input wire logic               ext_pspace_en,
  input wire logic               debug_read_disable,
  input wire logic               tap_enable
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic secured;
  assign secured = flash_security_bytes != prsc_unsecure_key;
  ////////////////////////////////////////////////////////////////////
  sequence s_periph_up;
    $rose(rst_out.periph_rst_n);
  endsequence
  // window length allowed two cycles of slack either side of 32
  sequence s_core_up;
    !rst_out.core_rst_n ##[30:34] rst_out.core_rst_n;
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_run_clocks_on: assert property (
    pwr_mode == prsc_mode_run |-> clk_en == 3'b111)
    else $error("clocks gated in run mode");
  a_wait_gates_core: assert property (
    pwr_mode == prsc_mode_wait |-> clk_en == 3'b001)
    else $error("wrong clock enables in wait mode");
  a_wait_irq_wake: assert property (
    pwr_mode == prsc_mode_wait && periph_irq |=> pwr_mode == prsc_mode_run)
    else $error("interrupt did not end wait");
  a_stop_holds: assert property (
    pwr_mode == prsc_mode_stop && !async_irq && !can_activity
    && !watchdog_reset_source |=> pwr_mode == prsc_mode_stop)
    else $error("stop left without wake source");
  a_stop_wakes: assert property (
    pwr_mode == prsc_mode_stop && (async_irq || can_activity)
    |=> pwr_mode == prsc_mode_run)
    else $error("stop not left on wake source");
  a_mode_needs_instr: assert property (
    $past(pwr_mode) == prsc_mode_run && pwr_mode != prsc_mode_run
    |-> $past(stop_instr || wait_instr))
    else $error("mode left run without instruction");
  a_stage_order: assert property (
    s_periph_up |-> s_core_up)
    else $error("core release not one window after peripherals");
  a_watchdog_reset: assert property (
    watchdog_reset_source |-> ##[1:3] !rst_out.periph_rst_n)
    else $error("watchdog did not reset");
  a_reset_clears: assert property (disable iff (1'b0)
    !resetn |-> rst_out == 3'b000)
    else $error("staged resets not held during reset");
  a_secure_lock: assert property (
    rst_out.app_run && secured |-> boot_mode == prsc_boot_secure
    && !ext_pspace_en && debug_read_disable)
    else $error("secured part not locked");
  a_boot_select: assert property (
    rst_out.app_run && !secured |-> !debug_read_disable && boot_mode ==
    (external_boot_pin ? prsc_boot_external : prsc_boot_internal))
    else $error("wrong unsecured boot mode");
  a_boot_vector: assert property (
    rst_out.app_run |-> boot_addr == prsc_secure_boot_addr)
    else $error("wrong boot address");
  a_tap_on: assert property (tap_enable)
    else $error("test access port disabled");
endmodule
`default_nettype wire

// file: verification/prsc_core_model.sv
// processor core model: turns bench requests into instruction pulses
// assumes the bench raises a request for one cycle
`timescale 1ns/1ps
`default_nettype none
module prsc_core_model
  import prsc_pkg::*;
(
  // clock and requests
  input  wire logic             core_clk,
  input  wire logic             go_stop,
  input  wire logic             go_wait,
  // controller state
  input  wire prsc_clk_en_type  clk_en,
  input  wire prsc_rst_out_type rst_out,
  // instruction pulses
  output logic                  stop_instr,
  output logic                  wait_instr
);
  logic live;
  // a gated or held core executes nothing; the pll is never touched
  assign live = clk_en.core_clk_en && rst_out.app_run;
  initial begin
    stop_instr = 1'b0;
    wait_instr = 1'b0;
  end
  always @(posedge core_clk) begin
    stop_instr <= go_stop && live;
    wait_instr <= go_wait && live;
  end
endmodule
`default_nettype wire

// file: verification/prsc_top_tb.sv
// testbench for prsc_top with a core model and bound checker
// assumes por_n stays high so the long power-on stretch is skipped
`timescale 1ns/1ps
`default_nettype none
module prsc_top_tb;
  import prsc_pkg::*;
  logic               core_clk, resetn, por_n, wd, reg_wr, reg_rd;
  logic               go_stop, go_wait, stop_instr, wait_instr;
  logic               periph_irq, async_irq, can_activity, ext_pin;
  logic               ext_pspace_en, debug_read_disable, tap_enable;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata, sec, rd;
  logic [23:0]        boot_addr;
  prsc_clk_en_type    clk_en;
  prsc_rst_out_type   rst_out;
  prsc_pwr_mode_type  pwr_mode;
  prsc_boot_mode_type boot_mode;
  int                 err_count = 0;
  int                 n_compared = 0;
  prsc_top i_prsc_top (.core_clk, .resetn, .por_n,
    .watchdog_reset_source(wd), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .stop_instr, .wait_instr, .periph_irq, .async_irq,
    .can_activity, .flash_security_bytes(sec), .external_boot_pin(ext_pin),
    .clk_en, .rst_out, .pwr_mode, .boot_mode, .boot_addr, .ext_pspace_en,
    .debug_read_disable, .tap_enable);
  prsc_core_model i_prsc_core_model (.core_clk, .go_stop, .go_wait,
    .clk_en, .rst_out, .stop_instr, .wait_instr);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // bounded wait; the bound covers two sync flops and three windows
  task automatic wait_run;
    for (int i = 0; i < 300 && rst_out.app_run !== 1'b1; i++) tick(1);
    #1 chk("app_run", 16'h1, {15'h0, rst_out.app_run});
  endtask
  task automatic boot(input logic [15:0] s, input logic p);
    @(posedge core_clk);
    resetn <= 1'b0;
    sec <= s;
    ext_pin <= p;
    tick(4);
    resetn <= 1'b1;
    wait_run();
  endtask
  task automatic pwr(input logic s, w);
    @(posedge core_clk);
    {go_stop, go_wait} <= {s, w};
    @(posedge core_clk);
    {go_stop, go_wait} <= 2'b00;
    tick(2);
    #1;
  endtask
  // one-cycle pulse of {periph_irq, async_irq, can_activity}
  task automatic ev(input logic [2:0] v);
    @(posedge core_clk);
    {periph_irq, async_irq, can_activity} <= v;
    @(posedge core_clk);
    {periph_irq, async_irq, can_activity} <= 3'b000;
    tick(1);
    #1;
  endtask
  task automatic pm(input prsc_pwr_mode_type m, input logic [2:0] c);
    chk("pwr_mode", {14'h0, m}, {14'h0, pwr_mode});
    chk("clk_en", {13'h0, c}, {13'h0, clk_en});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    // a hair after time zero, so every process reset by resetn sees the edge
    #1 {resetn, wd, reg_wr, reg_rd, go_stop, go_wait} = 6'h00;
    {periph_irq, async_irq, can_activity, por_n, ext_pin} = 5'h03;
    {reg_addr, reg_wdata, sec} = 36'h0;
    boot(16'h1234, 1'b1);
    chk("boot_mode", 16'h2, {14'h0, boot_mode});
    chk("pspace", 16'h0, {15'h0, ext_pspace_en});
    chk("dbg_dis", 16'h1, {15'h0, debug_read_disable});
    chk("boot_addr", 16'h0200, boot_addr[23:8]);
    rdr(prsc_addr_security);
    chk("secured", 16'h1, {15'h0, rd[0]});
    rdr(4'h3);
    chk("unmapped", 16'h0, rd);
    rdr(prsc_addr_status);
    chk("status", 16'h44, {9'h0, rd[6:0]});
    pm(prsc_mode_run, 3'b111);
    pwr(1'b0, 1'b1);
    pm(prsc_mode_wait, 3'b001);
    ev(3'b100);
    pm(prsc_mode_run, 3'b111);
    pwr(1'b1, 1'b1);
    chk("stop", 16'h2, {14'h0, pwr_mode});
    ev(3'b001);
    pm(prsc_mode_run, 3'b111);
    pwr(1'b1, 1'b0);
    ev(3'b010);
    pm(prsc_mode_run, 3'b111);
    wr(prsc_addr_control, 16'h0002);
    pwr(1'b0, 1'b1);
    pm(prsc_mode_run, 3'b111);
    wr(prsc_addr_control, 16'h0000);
    pwr(1'b0, 1'b1);
    pm(prsc_mode_wait, 3'b001);
    ev(3'b100);
    wr(prsc_addr_control, 16'h0004);
    wr(prsc_addr_control, 16'h0000);
    rdr(prsc_addr_control);
    chk("control", 16'h0004, rd);
    pwr(1'b1, 1'b0);
    pm(prsc_mode_run, 3'b111);
    wr(prsc_addr_control, 16'h0010);
    tick(3);
    #1 chk("sw_rst", 16'h0, {15'h0, rst_out.core_rst_n});
    wait_run();
    @(posedge core_clk);
    wd <= 1'b1;
    @(posedge core_clk);
    wd <= 1'b0;
    tick(3);
    #1 chk("wd_rst", 16'h0, {15'h0, rst_out.periph_rst_n});
    wait_run();
    pwr(1'b1, 1'b0);
    chk("stop_after_rst", 16'h2, {14'h0, pwr_mode});
    ev(3'b010);
    boot(prsc_unsecure_key, 1'b1);
    pwr(1'b1, 1'b0);
    chk("stop", 16'h2, {14'h0, pwr_mode});
    ev(3'b010);
    chk("boot_mode", 16'h1, {14'h0, boot_mode});
    chk("dbg_dis", 16'h0, {15'h0, debug_read_disable});
    rdr(prsc_addr_security);
    chk("secured", 16'h0, {15'h0, rd[0]});
    boot(prsc_unsecure_key, 1'b0);
    chk("boot_mode", 16'h0, {14'h0, boot_mode});
    final_report();
  end
  initial begin
    tick(20000);
    err_count++;
    final_report();
  end
endmodule
bind prsc_top prsc_top_chk i_prsc_top_chk (.core_clk, .resetn,
  .watchdog_reset_source, .stop_instr, .wait_instr, .periph_irq,
  .async_irq, .can_activity, .flash_security_bytes, .external_boot_pin,
  .clk_en, .rst_out, .pwr_mode, .boot_mode, .boot_addr, .ext_pspace_en,
  .debug_read_disable, .tap_enable);
`default_nettype wire
